/* File: hdl/iow_regs.vh */
// Constants for the I/O port watchdog timer.
`ifndef IOW_REGS_VH
`define IOW_REGS_VH
`define IOW_PORT_ADDR 8'h76
`define IOW_DISARM_CODE 8'h00
`define IOW_ARM_BIT 7
`define IOW_ACT_HI 6
`define IOW_ACT_LO 5
`define IOW_SEL_HI 2
`define IOW_SEL_LO 0
`define IOW_ACT_RESET 2'h0
`define IOW_ACT_IRQ10 2'h2
`define IOW_ACT_IRQ7 2'h3
`define IOW_RESERVED_MASK 8'h18
`define IOW_CLK_HZ 25000000
`define IOW_HALF_SEC_HZ 2
`define IOW_STEP_HALVES 12
`define IOW_SHORT_HALVES 6
`define IOW_RST_PULSE_CYC 16
`define IOW_BLINK_HALVES 1
`endif

/* File: hdl/iow_tick_gen.v */
// Half-second tick generator from the system clock.
`timescale 1ns/10ps
module iow_tick_gen #(
  parameter PRESCALE = 12500000
) (
  input wire clk,
  input wire srst,
  input wire clear,
  output reg tick_q
);
  reg [31:0] cnt_q;
  always @(posedge clk) begin
    if (srst || clear) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == PRESCALE - 1) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule

/* File: hdl/iow_sync2.v */
// Two-flop synchroniser for one level.
`timescale 1ns/10ps
module iow_sync2 (
  input wire clk,
  input wire srst,
  input wire din,
  output reg dout_q
);
  reg meta_q;
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule

/* File: hdl/iow_watchdog.v */
// Watchdog timer armed and retriggered by byte writes to one I/O port.
`timescale 1ns/10ps
`include "iow_regs.vh"
module iow_watchdog #(
  parameter PRESCALE = `IOW_CLK_HZ / `IOW_HALF_SEC_HZ,
  parameter RST_PULSE_CYC = `IOW_RST_PULSE_CYC
) (
  input wire clk,
  input wire srst,
  input wire io_wr_n,
  input wire [7:0] io_addr,
  input wire [7:0] io_data,
  output reg sys_reset_q,
  output reg irq7_q,
  output reg irq10_q,
  output reg led_q,
  output reg armed_q
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Only the three listed code sets are accepted; others leave it disarmed.
  function valid_code;
    input [7:0] c;
    begin
      valid_code = c[`IOW_ARM_BIT] &&
        ((c & `IOW_RESERVED_MASK) == 8'h00) &&
        (c[`IOW_ACT_HI:`IOW_ACT_LO] != 2'h1);
    end
  endfunction

  // Limit in half-seconds: 3 s for step 0, else step times 6 s.
  function [6:0] limit_halves;
    input [2:0] s;
    begin
      if (s == 3'h0) begin
        limit_halves = 7'd`IOW_SHORT_HALVES;
      end else begin
        limit_halves = s * 7'd`IOW_STEP_HALVES;
      end
    end
  endfunction

  // ----------------------------------------
  // Host write strobe
  // ----------------------------------------
  // The write strobe comes from the host bus, another timing domain, so it is
  // synchronised and its falling edge marks one write; data is held by then.
  // The strobe is inverted ahead of the synchroniser, so that both flops
  // and the edge detector reset to the idle level and no false write
  // is seen on the first edges after reset.
  wire wr_s;
  iow_sync2 u_wr_sync (
    .clk(clk),
    .srst(srst),
    .din(!io_wr_n),
    .dout_q(wr_s)
  );
  reg wr_prev_q;
  reg [7:0] addr_q1;
  reg [7:0] addr_q2;
  reg [7:0] data_q1;
  reg [7:0] data_q2;
  always @(posedge clk) begin
    if (srst) begin
      wr_prev_q <= 1'b0;
      addr_q1 <= 8'h00;
      addr_q2 <= 8'h00;
      data_q1 <= 8'h00;
      data_q2 <= 8'h00;
    end else begin
      wr_prev_q <= wr_s;
      addr_q1 <= io_addr;
      addr_q2 <= addr_q1;
      data_q1 <= io_data;
      data_q2 <= data_q1;
    end
  end
  wire port_wr = wr_s && !wr_prev_q &&
    (addr_q2 == `IOW_PORT_ADDR);

  // ----------------------------------------
  // Configuration and counting
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_COUNT = 3'b010;
  localparam ST_FIRED = 3'b100;

  reg [7:0] factor_q;
  reg [6:0] limit_q;
  reg [6:0] elapsed_q;
  reg [6:0] elapsed_d;
  reg [4:0] pulse_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  wire tick;
  wire restart = port_wr && valid_code(data_q2);
  wire fired = (state_q == ST_FIRED);

  // Any port write leaves the timer counting afresh or disarmed.
  function [2:0] after_write;
    input ok;
    begin
      if (ok) begin
        after_write = ST_COUNT;
      end else begin
        after_write = ST_IDLE;
      end
    end
  endfunction

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  iow_tick_gen #(
    .PRESCALE(PRESCALE)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .clear(restart),
    .tick_q(tick)
  );

  wire [1:0] act = factor_q[`IOW_ACT_HI:`IOW_ACT_LO];
  wire at_limit = (elapsed_q + 7'd1 >= limit_q);
  // A write in the expiry cycle wins, so a late retrigger still saves it.
  wire expire = (state_q == ST_COUNT) && !port_wr && tick && at_limit;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    elapsed_d = elapsed_q;
    case (state_q)
      ST_IDLE: begin
        if (port_wr) begin
          state_d = after_write(restart);
          elapsed_d = 7'd0;
        end
      end
      ST_COUNT: begin
        if (port_wr) begin
          state_d = after_write(restart);
          elapsed_d = 7'd0;
        end else if (expire) begin
          state_d = ST_FIRED;
        end else if (tick) begin
          elapsed_d = elapsed_q + 7'd1;
        end
      end
      ST_FIRED: begin
        if (port_wr) begin
          state_d = after_write(restart);
          elapsed_d = 7'd0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        elapsed_d = 7'd0;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      armed_q <= 1'b0;
      elapsed_q <= 7'd0;
    end else begin
      state_q <= state_d;
      armed_q <= (state_d != ST_IDLE);
      elapsed_q <= elapsed_d;
    end
  end

  // ----------------------------------------
  // Latched configuration
  // ----------------------------------------
  // The limit is worked out once per write, not on every cycle.
  always @(posedge clk) begin
    if (srst) begin
      factor_q <= `IOW_DISARM_CODE;
      limit_q <= 7'd`IOW_SHORT_HALVES;
    end else if (restart) begin
      factor_q <= data_q2;
      limit_q <= limit_halves(data_q2[`IOW_SEL_HI:`IOW_SEL_LO]);
    end
  end

  // ----------------------------------------
  // Expiry actions
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      sys_reset_q <= 1'b0;
      pulse_q <= 5'd0;
    end else if (expire && act == `IOW_ACT_RESET) begin
      pulse_q <= RST_PULSE_CYC[4:0];
      sys_reset_q <= 1'b1;
    end else if (pulse_q > 5'd1) begin
      pulse_q <= pulse_q - 5'd1;
    end else begin
      pulse_q <= 5'd0;
      sys_reset_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt lines
  // ----------------------------------------
  // Interrupt lines stay high until software rewrites the port, which
  // suits an edge-triggered controller and survives slow service.
  always @(posedge clk) begin
    if (srst) begin
      irq7_q <= 1'b0;
      irq10_q <= 1'b0;
    end else if (port_wr) begin
      irq7_q <= 1'b0;
      irq10_q <= 1'b0;
    end else if (expire) begin
      irq7_q <= (act == `IOW_ACT_IRQ7);
      irq10_q <= (act == `IOW_ACT_IRQ10);
    end
  end

  // ----------------------------------------
  // Indicator LED
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      led_q <= 1'b0;
    end else if (!armed_q || fired) begin
      led_q <= 1'b0;
    end else if (tick) begin
      led_q <= ~led_q;
    end
  end
endmodule

/* File: tb/iow_watchdog_sva.sv */
// Port-level checker for the watchdog, bound to its top module.
`timescale 1ns/10ps
module iow_watchdog_sva #(parameter RST_PULSE_CYC = 16) (
  input wire clk,
  input wire srst,
  input wire io_wr_n,
  input wire [7:0] io_addr,
  input wire [7:0] io_data,
  input wire sys_reset_q,
  input wire irq7_q,
  input wire irq10_q,
  input wire led_q,
  input wire armed_q
);
  wire hit = io_addr == 8'h76;
  wire ok = io_data[7] && io_data[4:3] == 2'h0 && io_data[6:5] != 2'h1;
  wire fire = sys_reset_q | irq7_q | irq10_q;
  // A counter, since the pulse length is a parameter and not a literal.
  reg [4:0] hi_q;
  always @(posedge clk) hi_q <= (srst || !sys_reset_q) ? 5'h00 : hi_q + 5'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  rst_clear_a: assert property (
    $fell(srst) |-> !armed_q && !fire && !led_q) else $error("reset");
  pulse_len_a: assert property (
    $fell(sys_reset_q) && !$past(srst) |-> hi_q == RST_PULSE_CYC)
    else $error("pulse");
  one_action_a: assert property (
    $onehot0({sys_reset_q, irq7_q, irq10_q})) else $error("action");
  led_idle_a: assert property (
    !armed_q && !$past(armed_q) |-> !led_q) else $error("led");
  arm_take_a: assert property (
    $fell(io_wr_n) && hit && ok |-> ##[2:8] armed_q) else $error("arm");
  disarm_take_a: assert property (
    $fell(io_wr_n) && hit && !ok |-> ##[2:8] !armed_q) else $error("off");
  foreign_wr_a: assert property (
    $fell(io_wr_n) && !hit && !armed_q |=> !armed_q [*6]) else $error("adr");
  armed_fire_a: assert property (
    $rose(fire) |-> armed_q || $past(armed_q)) else $error("idle");
  cover property ($rose(sys_reset_q));
  cover property ($rose(irq7_q));
  cover property ($rose(irq10_q));
endmodule
bind iow_watchdog iow_watchdog_sva #(.RST_PULSE_CYC(RST_PULSE_CYC)) sva_i (
  .clk(clk), .srst(srst), .io_wr_n(io_wr_n), .io_addr(io_addr),
  .io_data(io_data), .sys_reset_q(sys_reset_q), .irq7_q(irq7_q),
  .irq10_q(irq10_q), .led_q(led_q), .armed_q(armed_q));

/* File: tb/iow_host_model.sv */
// Host model that writes factor bytes to the watchdog port.
`timescale 1ns/10ps
module iow_host_model (
  input wire clk,
  output logic io_wr_n = 1'b1,
  output logic [7:0] io_addr = 8'h00,
  output logic [7:0] io_data = 8'h00
);
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_addr = a;
    io_data = d;
    io_wr_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 io_wr_n = 1'b1;
    repeat (5) @(posedge clk);
    // Released lines show the inverse, so a stale byte is never reused.
    #1 io_addr = ~a;
    io_data = ~d;
  endtask
endmodule

/* File: tb/io_port_watchdog_timer_tb.sv */
// Self-checking bench for the I/O port watchdog timer.
`timescale 1ns/10ps
module io_port_watchdog_timer_tb;
  logic clk = 1'b0, srst = 1'b1, fired = 1'b0, fire_clr = 1'b0, seen_led;
  wire io_wr_n, sys_reset_q, irq7_q, irq10_q, led_q, armed_q;
  wire [7:0] io_addr, io_data;
  int bad_count = 0, n_checks = 0, cnt;
  // Factor, {reset, line 7, line 10}, half seconds; then idle cases.
  logic [23:0] rows [6] = '{24'h800406, 24'h870454, 24'hE00206,
    24'hE70254, 24'hC1010C, 24'hC40130};
  logic [23:0] refs [4] = '{24'h827600, 24'h8276A0, 24'h827698, 24'h007782};
  always #20 clk = ~clk;
  always @(posedge clk)
    fired <= !srst && !fire_clr && (fired | sys_reset_q | irq7_q | irq10_q);
  task clr_fired;
    fire_clr = 1'b1;
    @(posedge clk);
    #1 fire_clr = 1'b0;
  endtask
  iow_host_model host (.clk(clk), .io_wr_n(io_wr_n), .io_addr(io_addr),
    .io_data(io_data));
  iow_watchdog #(.PRESCALE(10), .RST_PULSE_CYC(4)) uut (.clk(clk),
    .srst(srst), .io_wr_n(io_wr_n), .io_addr(io_addr), .io_data(io_data),
    .sys_reset_q(sys_reset_q), .irq7_q(irq7_q), .irq10_q(irq10_q),
    .led_q(led_q), .armed_q(armed_q));
  task chk(input logic [23:0] s, input logic [23:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task fire_chk(input logic [23:0] e);
    cnt = 0;
    seen_led = 1'b0;
    while ((sys_reset_q | irq7_q | irq10_q) !== 1'b1 && cnt < 1000) begin
      @(posedge clk);
      #1 cnt++;
      seen_led = seen_led | led_q;
    end
    if (cnt >= 1000) begin
      bad_count++;
      wrap_up();
    end
    chk({e[23:16], 5'h00, sys_reset_q, irq7_q, irq10_q,
      8'((cnt + 10) / 10)}, e);
    chk({23'h0, seen_led}, 24'h1);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk({armed_q, led_q, sys_reset_q, irq7_q, irq10_q}, 24'h0);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      host.wr(8'h76, rows[i][23:16]);
      fire_chk(rows[i]);
    end
    $display("factor table test done");
    host.wr(8'h76, 8'h80);
    // Cleared only after the write, which is what drops a line left high.
    clr_fired();
    repeat (2) begin
      repeat (30) @(posedge clk);
      host.wr(8'h76, 8'h80);
    end
    chk({23'h0, fired}, 24'h0);
    fire_chk(24'h800406);
    host.wr(8'h76, 8'h87);
    host.wr(8'h76, 8'hC0);
    fire_chk(24'hC00106);
    $display("retrigger test done");
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h76, refs[i][23:16]);
      host.wr(refs[i][15:8], refs[i][7:0]);
      clr_fired();
      repeat (250) @(posedge clk);
      chk({fired, armed_q, led_q}, 24'h0);
    end
    $display("refusal test done");
    wrap_up();
  end
endmodule
